// ===== rtl/tcic_counter_capture.sv
// 16-bit up/down counter with a shared high-byte latch and an input capture unit.
// Assumes a CPU on an 8-bit register port; pins are asynchronous and synchronised here.
//
// Functional notes
// - Sixteen-bit counter: increment, decrement, clear, top/bottom
// - Count low read loads high latch
// - High write to latch; low write loads all
// - Select zero stops counter; CPU access remains
// - CPU write beats clear or count
// - Waveform mode picks clear, up or down
// - Overflow flag set per mode, interrupt capable
// - Clock from prescaler or external pin
// - Matching edge copies count into capture
// - Capture flag set with copy, interrupt enable
// - Flag cleared by vector or one-write
// - Capture low read loads high latch
// - Capture writable only in capture-top modes
// - Select bit switches source to comparator
// - Filter output changes when four samples agree
// - Filter enable adds four cycles delay
// - Filter runs on undivided system clock
// - No capture in capture-top modes
// - New capture overwrites unread value
// - Software-driven pin level triggers capture
// - Top is max, fixed 8/9/10-bit, compare A or capture
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/10ps

module tcic_counter_capture (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Event pins
  input wire logic capture_pin,
  input wire logic comparator_output,
  input wire logic external_count_pin,
  input wire logic prescale_tick,
  // Interrupt requests and acknowledges
  input wire logic capture_vector_ack,
  input wire logic overflow_vector_ack,
  output logic capture_irq,
  output logic overflow_irq,
  // Counter status
  output logic count_at_top,
  output logic count_at_bottom
);

  tcic_pkg::tcic_bus_req_t bus;
  tcic_pkg::tcic_cnt_evt_t evt;
  logic [7:0] control_reg_a;
  logic [7:0] control_reg_b;
  logic [7:0] comparator_control_status;
  logic [7:0] irq_en_reg;
  logic [15:0] count_value;
  logic [15:0] capture_register;
  logic [15:0] cmpa_reg;
  logic [7:0] high_latch_reg;
  logic [7:0] rdata_reg;
  logic overflow_flag;
  logic capture_flag;
  logic count_dir_down_reg;
  logic [2:0] clock_select_field;
  logic [3:0] waveform_mode_field;
  logic noise_filter_enable;
  logic edge_rising;
  logic timer_clock;
  logic [1:0] ext_sync_reg;
  logic ext_prev_reg;
  logic [1:0] cap_pin_sync_reg;
  logic [1:0] cmp_sync_reg;
  logic [3:0] filt_pipe_reg;
  logic filt_out_reg;
  logic cap_prev_reg;
  logic cap_src;
  logic cap_level;
  logic cap_trigger;
  logic cap_top_mode;
  logic [15:0] top_value;
  logic at_top;
  logic at_bottom;
  logic cnt_wr;
  logic [15:0] count_next;
  logic ovf_set;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  assign clock_select_field = control_reg_b[tcic_pkg::CTRL_B_CS +: 3];
  assign waveform_mode_field = {control_reg_b[tcic_pkg::CTRL_B_WGM_HI +: 2],
                                control_reg_a[tcic_pkg::CTRL_A_WGM_LO +: 2]};
  assign noise_filter_enable = control_reg_b[tcic_pkg::CTRL_B_NOISE];
  assign edge_rising = control_reg_b[tcic_pkg::CTRL_B_EDGE];

  // Top selection per waveform mode
  function automatic tcic_pkg::tcic_top_sel_t top_kind(input logic [3:0] mode);
    case (mode)
      4'h1, 4'h5: top_kind = tcic_pkg::TCIC_TOP_8;
      4'h2, 4'h6: top_kind = tcic_pkg::TCIC_TOP_9;
      4'h3, 4'h7: top_kind = tcic_pkg::TCIC_TOP_10;
      4'h4, 4'h9, 4'hb, 4'hf: top_kind = tcic_pkg::TCIC_TOP_CMPA;
      4'h8, 4'ha, 4'hc, 4'he: top_kind = tcic_pkg::TCIC_TOP_CAP;
      default: top_kind = tcic_pkg::TCIC_TOP_MAX;
    endcase
  endfunction : top_kind

  // Dual-slope modes count up then down
  function automatic logic dual_slope(input logic [3:0] mode);
    case (mode)
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: dual_slope = 1'b1;
      default: dual_slope = 1'b0;
    endcase
  endfunction : dual_slope

  // Clear-on-top (single slope, non-wrapping at max)
  function automatic logic clear_on_top(input logic [3:0] mode);
    case (mode)
      4'h0: clear_on_top = 1'b0;
      default: clear_on_top = !dual_slope(mode);
    endcase
  endfunction : clear_on_top

  always_comb
  begin
    case (top_kind(waveform_mode_field))
      tcic_pkg::TCIC_TOP_8: top_value = tcic_pkg::TOP_8BIT;
      tcic_pkg::TCIC_TOP_9: top_value = tcic_pkg::TOP_9BIT;
      tcic_pkg::TCIC_TOP_10: top_value = tcic_pkg::TOP_10BIT;
      tcic_pkg::TCIC_TOP_CMPA: top_value = cmpa_reg;
      tcic_pkg::TCIC_TOP_CAP: top_value = capture_register;
      default: top_value = tcic_pkg::COUNT_MAX;
    endcase
  end

  assign cap_top_mode = (top_kind(waveform_mode_field) == tcic_pkg::TCIC_TOP_CAP);
  assign at_top = (count_value == top_value);
  assign at_bottom = (count_value == tcic_pkg::COUNT_BOTTOM);
  assign evt = '{at_top: at_top, at_bottom: at_bottom, overflow: ovf_set};
  assign count_at_top = evt.at_top;
  assign count_at_bottom = evt.at_bottom;

  // External count pin synchroniser and edge detect
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      ext_sync_reg <= 2'h0;
      ext_prev_reg <= 1'b0;
    end
    else
    begin
      ext_sync_reg <= {ext_sync_reg[0], external_count_pin};
      ext_prev_reg <= ext_sync_reg[1];
    end
  end

  // Timer clock enable: stopped, prescaled tick, or external edge
  always_comb
  begin
    case (clock_select_field)
      3'h0: timer_clock = 1'b0;
      3'h6: timer_clock = ext_prev_reg && !ext_sync_reg[1];
      3'h7: timer_clock = !ext_prev_reg && ext_sync_reg[1];
      default: timer_clock = prescale_tick;
    endcase
  end

  // Count next value per mode
  always_comb
  begin
    count_next = count_value;
    ovf_set = 1'b0;
    if (dual_slope(waveform_mode_field))
    begin
      if (count_dir_down_reg)
      begin
        count_next = count_value - 16'h0001;
        ovf_set = (count_value == 16'h0001);
      end
      else
      begin
        count_next = at_top ? (count_value - 16'h0001) : (count_value + 16'h0001);
      end
    end
    else if (clear_on_top(waveform_mode_field) && at_top)
    begin
      count_next = tcic_pkg::COUNT_BOTTOM;
      ovf_set = (waveform_mode_field > 4'h4) && (waveform_mode_field != 4'hc);
    end
    else
    begin
      count_next = count_value + 16'h0001;
      ovf_set = (count_value == tcic_pkg::COUNT_MAX);
    end
  end

  assign cnt_wr = bus.wr && (bus.addr == tcic_pkg::ADDR_CNT_LO);

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      count_value <= tcic_pkg::COUNT_BOTTOM;
    else if (cnt_wr)
      count_value <= {high_latch_reg, bus.wdata};
    else if (timer_clock)
      count_value <= count_next;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      count_dir_down_reg <= 1'b0;
    else if (!dual_slope(waveform_mode_field))
      count_dir_down_reg <= 1'b0;
    else if (timer_clock && !cnt_wr)
    begin
      if (at_top)
        count_dir_down_reg <= 1'b1;
      else if (count_value == 16'h0001 && count_dir_down_reg)
        count_dir_down_reg <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      control_reg_a <= tcic_pkg::CTRL_RESET;
      control_reg_b <= tcic_pkg::CTRL_RESET;
      comparator_control_status <= tcic_pkg::CTRL_RESET;
      irq_en_reg <= tcic_pkg::CTRL_RESET;
      cmpa_reg <= tcic_pkg::COUNT_MAX;
    end
    else if (bus.wr)
    begin
      case (bus.addr)
        tcic_pkg::ADDR_CTRL_A: control_reg_a <= bus.wdata;
        tcic_pkg::ADDR_CTRL_B: control_reg_b <= bus.wdata;
        tcic_pkg::ADDR_CMP_CTRL: comparator_control_status <= bus.wdata;
        tcic_pkg::ADDR_IRQ_EN: irq_en_reg <= bus.wdata;
        tcic_pkg::ADDR_CMPA_LO: cmpa_reg <= {high_latch_reg, bus.wdata};
        default: cmpa_reg <= cmpa_reg;
      endcase
    end
  end

  // Capture source synchronisers; the pin also sees software port drive
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      cap_pin_sync_reg <= 2'h0;
      cmp_sync_reg <= 2'h0;
    end
    else
    begin
      cap_pin_sync_reg <= {cap_pin_sync_reg[0], capture_pin};
      cmp_sync_reg <= {cmp_sync_reg[0], comparator_output};
    end
  end

  // Switching source may itself look like an edge; software clears the flag
  assign cap_src = comparator_control_status[tcic_pkg::CMP_CTRL_SEL] ?
                   cmp_sync_reg[1] : cap_pin_sync_reg[1];

  // Four-deep filter on the undivided clock
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      filt_pipe_reg <= 4'h0;
      filt_out_reg <= 1'b0;
    end
    else
    begin
      filt_pipe_reg <= {filt_pipe_reg[tcic_pkg::NOISE_DEPTH-2:0], cap_src};
      // Newest sample counts as the fourth, so the filter costs exactly four cycles
      if ({filt_pipe_reg[tcic_pkg::NOISE_DEPTH-2:0], cap_src} == 4'hf)
        filt_out_reg <= 1'b1;
      else if ({filt_pipe_reg[tcic_pkg::NOISE_DEPTH-2:0], cap_src} == 4'h0)
        filt_out_reg <= 1'b0;
    end
  end

  // Filtered path is four cycles later than the bypass
  assign cap_level = noise_filter_enable ? filt_out_reg : cap_src;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      cap_prev_reg <= 1'b0;
    else
      cap_prev_reg <= cap_level;
  end

  assign cap_trigger = !cap_top_mode &&
                       (edge_rising ? (cap_level && !cap_prev_reg) : (!cap_level && cap_prev_reg));

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      capture_register <= tcic_pkg::COUNT_BOTTOM;
    else if (cap_trigger)
      capture_register <= count_value;
    else if (bus.wr && bus.addr == tcic_pkg::ADDR_CAP_LO && cap_top_mode)
      capture_register <= {high_latch_reg, bus.wdata};
  end

  // Flags: hardware set wins over any clear in the same cycle
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      capture_flag <= 1'b0;
    else if (cap_trigger)
      capture_flag <= 1'b1;
    else if (capture_vector_ack ||
             (bus.wr && bus.addr == tcic_pkg::ADDR_FLAGS && bus.wdata[tcic_pkg::FLAG_CAP]))
      capture_flag <= 1'b0;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      overflow_flag <= 1'b0;
    else if (timer_clock && !cnt_wr && ovf_set)
      overflow_flag <= 1'b1;
    else if (overflow_vector_ack ||
             (bus.wr && bus.addr == tcic_pkg::ADDR_FLAGS && bus.wdata[tcic_pkg::FLAG_OVF]))
      overflow_flag <= 1'b0;
  end

  assign capture_irq = capture_flag && irq_en_reg[tcic_pkg::FLAG_CAP];
  assign overflow_irq = overflow_flag && irq_en_reg[tcic_pkg::FLAG_OVF];

  // Shared high-byte latch
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      high_latch_reg <= 8'h00;
    else if (bus.rd && bus.addr == tcic_pkg::ADDR_CNT_LO)
      high_latch_reg <= count_value[15:8];
    else if (bus.rd && bus.addr == tcic_pkg::ADDR_CAP_LO)
      high_latch_reg <= capture_register[15:8];
    else if (bus.wr && (bus.addr == tcic_pkg::ADDR_CNT_HI || bus.addr == tcic_pkg::ADDR_CAP_HI ||
                        bus.addr == tcic_pkg::ADDR_CMPA_HI))
      high_latch_reg <= bus.wdata;
  end

  // Read data, one cycle after the strobe and only then
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      rdata_reg <= 8'h00;
    else if (bus.rd)
    begin
      case (bus.addr)
        tcic_pkg::ADDR_CTRL_A: rdata_reg <= control_reg_a;
        tcic_pkg::ADDR_CTRL_B: rdata_reg <= control_reg_b;
        tcic_pkg::ADDR_CNT_LO: rdata_reg <= count_value[7:0];
        tcic_pkg::ADDR_CNT_HI: rdata_reg <= high_latch_reg;
        tcic_pkg::ADDR_CAP_LO: rdata_reg <= capture_register[7:0];
        tcic_pkg::ADDR_CAP_HI: rdata_reg <= high_latch_reg;
        tcic_pkg::ADDR_CMPA_LO: rdata_reg <= cmpa_reg[7:0];
        tcic_pkg::ADDR_CMPA_HI: rdata_reg <= cmpa_reg[15:8];
        tcic_pkg::ADDR_FLAGS: rdata_reg <= {2'h0, capture_flag, 4'h0, overflow_flag};
        tcic_pkg::ADDR_IRQ_EN: rdata_reg <= irq_en_reg;
        tcic_pkg::ADDR_CMP_CTRL: rdata_reg <= comparator_control_status;
        default: rdata_reg <= 8'h00;
      endcase
    end
    else
      rdata_reg <= 8'h00;
  end

  assign reg_rdata = rdata_reg;

endmodule : tcic_counter_capture

// ===== rtl/tcic_pkg.sv
// Package for the 16-bit counter with input capture: register map, field positions, modes.
// Assumes an 8-bit register port with one-cycle strobes and read data one cycle later.
package tcic_pkg;

  // Register byte offsets (chosen map)
  localparam logic [3:0] ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B = 4'h1;
  localparam logic [3:0] ADDR_CNT_LO = 4'h2;
  localparam logic [3:0] ADDR_CNT_HI = 4'h3;
  localparam logic [3:0] ADDR_CAP_LO = 4'h4;
  localparam logic [3:0] ADDR_CAP_HI = 4'h5;
  localparam logic [3:0] ADDR_CMPA_LO = 4'h6;
  localparam logic [3:0] ADDR_CMPA_HI = 4'h7;
  localparam logic [3:0] ADDR_FLAGS = 4'h8;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h9;
  localparam logic [3:0] ADDR_CMP_CTRL = 4'ha;

  // Control A: waveform mode bits 1:0
  localparam int CTRL_A_WGM_LO = 0;
  // Control B fields
  localparam int CTRL_B_CS = 0;
  localparam int CTRL_B_WGM_HI = 3;
  localparam int CTRL_B_EDGE = 6;
  localparam int CTRL_B_NOISE = 7;
  // Flags and enables
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CAP = 5;
  // Comparator control: capture source select
  localparam int CMP_CTRL_SEL = 2;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam int NOISE_DEPTH = 4;

  typedef enum logic [2:0] {
    TCIC_TOP_MAX,
    TCIC_TOP_8,
    TCIC_TOP_9,
    TCIC_TOP_10,
    TCIC_TOP_CMPA,
    TCIC_TOP_CAP
  } tcic_top_sel_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tcic_bus_req_t;

  typedef struct packed {
    logic at_top;
    logic at_bottom;
    logic overflow;
  } tcic_cnt_evt_t;

endpackage : tcic_pkg

// ===== verif/tcic_counter_capture_properties.sv
// Checker for the counter with input capture, on the top ports only.
// Assumes one clock domain and the register map of the package.
`timescale 1ns/10ps
module tcic_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Event pins and acknowledges
  input wire logic capture_pin,
  input wire logic comparator_output,
  input wire logic capture_vector_ack,
  input wire logic overflow_vector_ack,
  // Interrupts and status
  input wire logic capture_irq,
  input wire logic overflow_irq,
  input wire logic count_at_top,
  input wire logic count_at_bottom
);
  logic [3:0] quiet;
  logic [7:0] ctrl_b;
  logic hi_zero;
  // Edges since the capture source last moved; filtered captures land by 7
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
      quiet <= 4'h0;
    else if ($changed(capture_pin) || $changed(comparator_output)
             || (reg_wr && reg_addr == tcic_pkg::ADDR_CMP_CTRL))
      quiet <= 4'h0;
    else if (quiet != 4'hf)
      quiet <= quiet + 4'h1;
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
      ctrl_b <= tcic_pkg::CTRL_RESET;
    else if (reg_wr && reg_addr == tcic_pkg::ADDR_CTRL_B)
      ctrl_b <= reg_wdata;
  // Latch known zero only after a zero high-byte write; any low read spoils it
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
      hi_zero <= 1'b0;
    else if (reg_wr && reg_addr inside {4'h3, 4'h5, 4'h7})
      hi_zero <= reg_wdata == 8'h00;
    else if (reg_rd && reg_addr inside {4'h2, 4'h4, 4'h6})
      hi_zero <= 1'b0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_ctrlb_read;
    reg_rd && reg_addr == tcic_pkg::ADDR_CTRL_B |=> (reg_rdata & 8'hdf) == (ctrl_b & 8'hdf);
  endproperty
  a_ctrlb_read: assert property (p_ctrlb_read) else $error("control B readback wrong");
  property p_cap_clr_wr;
    quiet >= 4'h8 && reg_wr && reg_addr == tcic_pkg::ADDR_FLAGS && reg_wdata[5] |=> !capture_irq;
  endproperty
  a_cap_clr_wr: assert property (p_cap_clr_wr) else $error("capture flag kept after clear");
  property p_cap_clr_ack;
    quiet >= 4'h8 && capture_vector_ack |=> !capture_irq;
  endproperty
  a_cap_clr_ack: assert property (p_cap_clr_ack) else $error("capture flag kept after ack");
  property p_no_cap_quiet;
    quiet >= 4'h8 && !reg_wr |=> !$rose(capture_irq);
  endproperty
  a_no_cap_quiet: assert property (p_no_cap_quiet) else $error("capture without event");
  property p_stop_stable;
    ctrl_b[2:0] == 3'h0 && !reg_wr |=> $stable(count_at_bottom);
  endproperty
  a_stop_stable: assert property (p_stop_stable) else $error("stopped counter moved");
  property p_write_zero;
    hi_zero && reg_wr && reg_addr == tcic_pkg::ADDR_CNT_LO && reg_wdata == 8'h00 |=> count_at_bottom;
  endproperty
  a_write_zero: assert property (p_write_zero) else $error("count write of zero lost");
  property p_ovf_ack;
    overflow_vector_ack && ctrl_b[2:0] == 3'h0 |=> !overflow_irq;
  endproperty
  a_ovf_ack: assert property (p_ovf_ack) else $error("overflow flag kept after ack");
  c_cap: cover property ($rose(capture_irq));
  c_ovf: cover property ($rose(overflow_irq));
  c_top: cover property (count_at_top);
endmodule : tcic_chk

// ===== verif/tcic_cpu_model.sv
// CPU side of the byte register port: one strobe per access.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/10ps
module tcic_cpu_model (
  // Clock
  input wire logic core_clk,
  // Register port
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Idle address and data are inverted so stale values never pass
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    // Let the write settle before the caller looks at outputs
    @(negedge core_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr(lo + 4'h1, v[15:8]);
    wr(lo, v[7:0]);
  endtask : wr16
  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    rd(lo, v[7:0]);
    rd(lo + 4'h1, v[15:8]);
  endtask : rd16
endmodule : tcic_cpu_model

// ===== verif/tcic_counter_capture_test.sv
// Bench for the counter with input capture; pins driven here.
// Assumes the CPU model for all register traffic.
`timescale 1ns/10ps
module tcic_counter_capture_test;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_wr;
  logic reg_rd;
  logic capture_pin = 1'b0;
  logic comparator_output = 1'b0;
  logic external_count_pin = 1'b0;
  logic prescale_tick = 1'b0;
  logic capture_vector_ack = 1'b0;
  logic overflow_vector_ack = 1'b0;
  logic capture_irq;
  logic overflow_irq;
  logic count_at_top;
  logic count_at_bottom;
  int fail_count = 0;
  int n_compared = 0;
  logic [15:0] v;
  always #20 core_clk = ~core_clk;
  tcic_counter_capture uut (.*);
  tcic_cpu_model cpu (.*);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask : cyc
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      prescale_tick <= 1'b1;
      @(posedge core_clk);
      prescale_tick <= 1'b0;
    end
  endtask : tick
  // Unfiltered capture lands in about 3 cycles, so 5 is settled
  task automatic pin(input logic lvl, input logic irq);
    @(posedge core_clk);
    capture_pin <= lvl;
    cyc(5);
    chk(capture_irq, irq);
  endtask : pin
  task automatic t_count;
    chk({count_at_bottom, capture_irq, overflow_irq}, 16'h4);
    cpu.rd(4'hf, v[7:0]);
    chk(v[7:0], 8'h00);
    cpu.wr16(tcic_pkg::ADDR_CNT_LO, 16'h12ff);
    cpu.wr(tcic_pkg::ADDR_CTRL_B, 8'h01);
    cpu.rd(tcic_pkg::ADDR_CNT_LO, v[7:0]);
    tick(1);
    cpu.rd(tcic_pkg::ADDR_CNT_HI, v[15:8]);
    chk(v, 16'h12ff);
    cpu.rd16(tcic_pkg::ADDR_CNT_LO, v);
    chk(v, 16'h1300);
    cpu.wr(tcic_pkg::ADDR_CNT_HI, 8'h00);
    fork
      cpu.wr(tcic_pkg::ADDR_CNT_LO, 8'h00);
      tick(1);
    join
    cpu.rd16(tcic_pkg::ADDR_CNT_LO, v);
    chk(v, 16'h0000);
    cpu.wr(tcic_pkg::ADDR_CTRL_B, 8'h07);
    repeat (3)
    begin
      @(posedge core_clk);
      external_count_pin <= 1'b1;
      cyc(3);
      @(posedge core_clk);
      external_count_pin <= 1'b0;
      cyc(3);
    end
    cpu.wr(tcic_pkg::ADDR_CTRL_B, 8'h00);
    tick(2);
    cpu.rd16(tcic_pkg::ADDR_CNT_LO, v);
    chk(v, 16'h0003);
  endtask : t_count
  task automatic t_ovf;
    cpu.wr(tcic_pkg::ADDR_IRQ_EN, 8'h21);
    cpu.wr(tcic_pkg::ADDR_CTRL_B, 8'h01);
    cpu.wr16(tcic_pkg::ADDR_CNT_LO, 16'hffff);
    chk(count_at_top, 1'b1);
    tick(1);
    cyc(2);
    chk({overflow_irq, count_at_bottom}, 16'h3);
    cpu.wr(tcic_pkg::ADDR_CTRL_B, 8'h00);
    @(posedge core_clk);
    overflow_vector_ack <= 1'b1;
    @(posedge core_clk);
    overflow_vector_ack <= 1'b0;
    cyc(1);
    chk(overflow_irq, 1'b0);
    cpu.wr(tcic_pkg::ADDR_CTRL_A, 8'h01);
    cpu.wr16(tcic_pkg::ADDR_CNT_LO, 16'h00fe);
    cpu.wr(tcic_pkg::ADDR_CTRL_B, 8'h01);
    tick(3);
    cpu.wr(tcic_pkg::ADDR_CTRL_B, 8'h00);
    cpu.rd16(tcic_pkg::ADDR_CNT_LO, v);
    chk(v, 16'h00fd);
    cpu.wr(tcic_pkg::ADDR_CTRL_A, 8'h00);
  endtask : t_ovf
  task automatic t_capture;
    cpu.wr16(tcic_pkg::ADDR_CNT_LO, 16'h0abc);
    cpu.wr(tcic_pkg::ADDR_CTRL_B, 8'h40);
    pin(1'b1, 1'b1);
    cpu.rd16(tcic_pkg::ADDR_CAP_LO, v);
    chk(v, 16'h0abc);
    cpu.wr(tcic_pkg::ADDR_CTRL_B, 8'h00);
    cpu.wr(tcic_pkg::ADDR_FLAGS, 8'h20);
    chk(capture_irq, 1'b0);
    cpu.wr16(tcic_pkg::ADDR_CNT_LO, 16'h0123);
    pin(1'b0, 1'b1);
    cpu.rd16(tcic_pkg::ADDR_CAP_LO, v);
    chk(v, 16'h0123);
    @(posedge core_clk);
    capture_vector_ack <= 1'b1;
    @(posedge core_clk);
    capture_vector_ack <= 1'b0;
    cyc(1);
    chk(capture_irq, 1'b0);
    pin(1'b1, 1'b0);
    cpu.wr(tcic_pkg::ADDR_CMP_CTRL, 8'h04);
    cpu.wr(tcic_pkg::ADDR_FLAGS, 8'h20);
    pin(1'b0, 1'b0);
    cpu.wr(tcic_pkg::ADDR_CTRL_B, 8'h40);
    @(posedge core_clk);
    comparator_output <= 1'b1;
    cyc(5);
    chk(capture_irq, 1'b1);
    cpu.wr(tcic_pkg::ADDR_CMP_CTRL, 8'h00);
    cpu.wr(tcic_pkg::ADDR_FLAGS, 8'h20);
    pin(1'b1, 1'b1);
  endtask : t_capture
  task automatic t_filter;
    cpu.wr(tcic_pkg::ADDR_CTRL_B, 8'h80);
    cpu.wr(tcic_pkg::ADDR_FLAGS, 8'h20);
    @(posedge core_clk);
    capture_pin <= 1'b0;
    @(posedge core_clk);
    @(posedge core_clk);
    capture_pin <= 1'b1;
    cyc(10);
    chk(capture_irq, 1'b0);
    @(posedge core_clk);
    capture_pin <= 1'b0;
    cyc(6);
    chk(capture_irq, 1'b0);
    cyc(1);
    chk(capture_irq, 1'b1);
  endtask : t_filter
  task automatic t_captop;
    cpu.wr(tcic_pkg::ADDR_FLAGS, 8'h20);
    cpu.wr(tcic_pkg::ADDR_CTRL_B, 8'h18);
    cpu.wr16(tcic_pkg::ADDR_CAP_LO, 16'h0040);
    cpu.rd16(tcic_pkg::ADDR_CAP_LO, v);
    chk(v, 16'h0040);
    pin(1'b1, 1'b0);
    pin(1'b0, 1'b0);
    cpu.wr16(tcic_pkg::ADDR_CNT_LO, 16'h0040);
    chk(count_at_top, 1'b1);
    cpu.wr(tcic_pkg::ADDR_CTRL_B, 8'h00);
    cpu.wr16(tcic_pkg::ADDR_CAP_LO, 16'h5555);
    cpu.rd16(tcic_pkg::ADDR_CAP_LO, v);
    chk(v, 16'h0040);
  endtask : t_captop
  initial
  begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    cyc(1);
    t_count;
    t_ovf;
    t_capture;
    t_filter;
    t_captop;
    final_report;
  end
  // Whole run is a few hundred cycles; 25k cycles means a hang
  initial
  begin
    #1000000;
    fail_count++;
    final_report;
  end
endmodule : tcic_counter_capture_test
bind tcic_counter_capture tcic_chk chk (.*);
